/* core/irap_pkg.sv */
// shared constants, types and helpers for the two-wire register access port
package irap_pkg;
  localparam int          PTR_W      = 6;
  localparam int          BYTE_W     = 8;
  localparam int          FIFO_DEPTH = 16;
  localparam logic [6:0]  SLV_ADDR   = 7'h51;
  localparam logic [5:0]  PTR_MAX    = 6'h2f;
  localparam logic [5:0]  PTR_MIN    = 6'h00;
  localparam logic [5:0]  PTR_RST    = 6'h00;
  localparam logic [3:0]  BITS_BYTE  = 4'h8;
  localparam logic [3:0]  BIT_LAST   = 4'h7;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDAT, S_ACK, S_RLOAD, S_RDAT, S_RACK, S_IGN
  } irap_state_t;

  typedef struct packed {
    logic [PTR_W-1:0]  addr;
    logic [BYTE_W-1:0] data;
  } irap_wr_t;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_MAX) ? PTR_MIN : p + 6'h01;
  endfunction
endpackage

/* core/irap_top.sv */
// two-wire slave front end with write fifo toward the register space
// Functional notes
// - write address then one pointer byte, 00h-2Fh
// - out-of-range pointer: ack all, change nothing
// - any number of write bytes accepted
// - store byte at pointer, increment, wrap 2Fh
// - read starts at current pointer
// - first read byte driven right after address
// - pointer increments per read byte, wraps
// - answer only to address 1010 001
// - acknowledge every received byte in write
// - port silent while on battery supply
`timescale 1ns/1ps

module irap_fifo #(
  parameter int W = 14,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q, wp_d;
  logic [AW:0]  rp_q, rp_d;
  logic         full, empty;

  assign full        = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty       = (wp_q == rp_q);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rp_q[AW-1:0]];

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (i_in_valid && !full) wp_d = wp_q + 1'b1;
    if (i_out_ready && !empty) rp_d = rp_q + 1'b1;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (i_in_valid && !full) mem[wp_q[AW-1:0]] <= i_in_data;
  end
endmodule

module irap_top
  import irap_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // supply state
  input  wire logic              i_on_battery,
  // two-wire pins
  input  wire logic              i_scl,
  output logic                   o_scl_out,
  output logic                   o_scl_oe,
  input  wire logic              i_sda_in,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  // register write stream
  output logic                   o_wr_valid,
  input  wire logic              i_wr_ready,
  output logic [PTR_W-1:0]       o_wr_addr,
  output logic [BYTE_W-1:0]      o_wr_data,
  // register read port
  output logic [PTR_W-1:0]       o_rd_addr,
  input  wire logic [BYTE_W-1:0] i_rd_data
);
  irap_state_t        state_q, state_d;
  irap_state_t        ret_q, ret_d;
  logic [3:0]         cnt_q, cnt_d;
  logic [7:0]         sh_q, sh_d;
  logic [PTR_W-1:0]   ptr_q, ptr_d;
  logic               disc_q, disc_d;
  logic               nack_q, nack_d;
  logic               sda_oe_q, sda_oe_d;
  logic               scl_oe_q, scl_oe_d;
  logic               scl_q, sda_q;
  logic               scl_rise, scl_fall;
  logic               start_c, stop_c;
  logic               push_valid, push_ready;
  irap_wr_t           push_data, pop_data;

  assign scl_rise  = i_scl && !scl_q;
  assign scl_fall  = !i_scl && scl_q;
  assign start_c   = scl_q && i_scl && sda_q && !i_sda_in;
  assign stop_c    = scl_q && i_scl && !sda_q && i_sda_in;
  assign push_data = '{addr: ptr_q, data: sh_q};
  assign o_rd_addr = ptr_q;
  assign o_sda_out = 1'b0;
  assign o_scl_out = 1'b0;
  assign o_sda_oe  = sda_oe_q;
  assign o_scl_oe  = scl_oe_q;
  assign o_wr_addr = pop_data.addr;
  assign o_wr_data = pop_data.data;

  // writes queue here; a full queue stretches the clock
  irap_fifo #(.W($bits(irap_wr_t)), .D(DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_data),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (pop_data)
  );

  always_comb begin
    state_d    = state_q;
    ret_d      = ret_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    ptr_d      = ptr_q;
    disc_d     = disc_q;
    nack_d     = nack_q;
    sda_oe_d   = sda_oe_q;
    scl_oe_d   = 1'b0;
    push_valid = 1'b0;
    if (i_on_battery) begin
      state_d  = S_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_c) begin
      state_d  = S_ADDR;
      cnt_d    = 4'h0;
      disc_d   = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      state_d  = S_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        S_ADDR, S_PTR, S_WDAT: begin
          if (cnt_q != BITS_BYTE && scl_rise) begin
            sh_d  = {sh_q[6:0], i_sda_in};
            cnt_d = cnt_q + 4'h1;
          end else if (cnt_q == BITS_BYTE && !i_scl) begin
            if (state_q == S_ADDR) begin
              if (sh_q[7:1] == SLV_ADDR) begin
                sda_oe_d = 1'b1;
                state_d  = S_ACK;
                ret_d    = sh_q[0] ? S_RLOAD : S_PTR;
              end else begin
                state_d = S_IGN;
              end
            end else if (state_q == S_PTR) begin
              sda_oe_d = 1'b1;
              state_d  = S_ACK;
              ret_d    = S_WDAT;
              if (sh_q <= {2'b00, PTR_MAX}) begin
                ptr_d = sh_q[PTR_W-1:0];
              end else begin
                disc_d = 1'b1;
              end
            end else if (disc_q) begin
              sda_oe_d = 1'b1;
              state_d  = S_ACK;
            end else begin
              push_valid = 1'b1;
              if (push_ready) begin
                sda_oe_d = 1'b1;
                scl_oe_d = scl_oe_q; // hold scl low one more cycle so the ack settles first
                state_d  = S_ACK;
                ptr_d    = ptr_inc(ptr_q);
              end else begin
                scl_oe_d = 1'b1;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            state_d  = ret_q;
            cnt_d    = 4'h0;
          end
        end
        S_RLOAD: begin
          // pending writes must land before the read samples the space
          if (!o_wr_valid) begin
            sh_d     = i_rd_data;
            sda_oe_d = !i_rd_data[7];
            scl_oe_d = scl_oe_q; // first data bit settles before scl is let go
            state_d  = S_RDAT;
            cnt_d    = 4'h0;
          end else begin
            scl_oe_d = 1'b1;
          end
        end
        S_RDAT: begin
          if (scl_fall) begin
            if (cnt_q == BIT_LAST) begin
              sda_oe_d = 1'b0;
              state_d  = S_RACK;
              ptr_d    = ptr_inc(ptr_q);
            end else begin
              sh_d     = {sh_q[6:0], 1'b0};
              sda_oe_d = !sh_q[6];
              cnt_d    = cnt_q + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) nack_d = i_sda_in;
          if (scl_fall) begin
            state_d = nack_q ? S_IGN : S_RLOAD;
          end
        end
        default: begin
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q  <= S_IDLE;
      ret_q    <= S_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= PTR_RST;
      disc_q   <= 1'b0;
      nack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      state_q  <= state_d;
      ret_q    <= ret_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      ptr_q    <= ptr_d;
      disc_q   <= disc_d;
      nack_q   <= nack_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      scl_q    <= i_scl;
      sda_q    <= i_sda_in;
    end
  end

  chk_ptr_range: assert property (@(posedge i_clock) disable iff (i_rst) ptr_q <= PTR_MAX)
    else $error("pointer left the 00h-2Fh range");
  chk_discard_nopush: assert property (@(posedge i_clock) disable iff (i_rst)
    disc_q |-> !push_valid) else $error("discarded transfer pushed a write");
  chk_write_ptr_step: assert property (@(posedge i_clock) disable iff (i_rst)
    push_valid && push_ready && !i_on_battery |=> ptr_q == ptr_inc($past(ptr_q)))
    else $error("write did not advance pointer by one");
  chk_read_first: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == S_RLOAD && !o_wr_valid && !i_on_battery && !start_c && !stop_c
    |=> state_q == S_RDAT && sh_q == $past(i_rd_data))
    else $error("first read byte not loaded");
  chk_read_ptr_step: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == S_RDAT && cnt_q == BIT_LAST && scl_fall && !i_on_battery && !start_c && !stop_c
    |=> ptr_q == ptr_inc($past(ptr_q)) && state_q == S_RACK)
    else $error("read did not advance pointer by one");
  chk_addr_match: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == S_ADDR && cnt_q == BITS_BYTE && !i_scl && sh_q[7:1] == SLV_ADDR
    && !i_on_battery && !start_c && !stop_c |=> state_q == S_ACK && o_sda_oe)
    else $error("own address not acknowledged");
  chk_ack_drive: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == S_ACK |-> o_sda_oe) else $error("acknowledge not driven low");
  chk_battery_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    i_on_battery |=> !o_sda_oe && !o_scl_oe && state_q == S_IDLE)
    else $error("port active on battery");
  chk_ptr_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == S_IDLE |=> $stable(ptr_q)) else $error("pointer lost between transfers");
  chk_foreign_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == S_IGN && !start_c |=> !o_sda_oe && state_q inside {S_IGN, S_IDLE})
    else $error("ignored transfer drove the bus");
endmodule

/* verification/irap_master.sv */
// two-wire bus master model for the serial pins
`timescale 1ns/1ps

module irap_master (
  // clock
  input  wire logic i_clock,
  // resolved wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // pull-downs and hang flag
  output logic      o_scl_low,
  output logic      o_sda_low,
  output logic      o_hang
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_hang    = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // release scl and wait out clock stretching under a bound
  task automatic scl_up;
    int k;
    o_scl_low <= 1'b0;
    tick(1);
    for (k = 0; k < 5000 && i_scl !== 1'b1; k++) tick(1);
    if (k == 5000) o_hang <= 1'b1;
    tick(4);
  endtask

  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= !b;
    tick(4);
    scl_up;
    r = i_sda;
    o_scl_low <= 1'b1;
    tick(4);
  endtask

  // start, also used as repeated start
  task automatic start;
    o_sda_low <= 1'b0;
    tick(4);
    scl_up;
    o_sda_low <= 1'b1;
    tick(4);
    o_scl_low <= 1'b1;
    tick(4);
  endtask

  task automatic stop;
    o_sda_low <= 1'b1;
    tick(4);
    scl_up;
    o_sda_low <= 1'b0;
    tick(4);
  endtask

  // msb first, then the ninth bit as the caller asks
  task automatic xfer(input logic [7:0] tx, input logic a_in, output logic [7:0] rx, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(a_in, a);
  endtask
endmodule

/* verification/irap_top_tb.sv */
// self-checking bench for the two-wire register access port
`timescale 1ns/1ps

module irap_top_tb;
  import irap_pkg::*;

  logic              i_clock  = 1'b0;
  logic              i_rst    = 1'b1;
  logic              bat      = 1'b0;
  logic              rdy      = 1'b0;
  logic              stall    = 1'b0;
  logic              scl;
  logic              sda;
  logic              m_scl;
  logic              m_sda;
  logic              hang;
  logic              scl_oe;
  logic              sda_oe;
  logic              scl_out;
  logic              sda_out;
  logic              wr_valid;
  logic              ack;
  logic [PTR_W-1:0]  wr_addr;
  logic [PTR_W-1:0]  rd_addr;
  logic [PTR_W-1:0]  ep       = 6'h00;
  logic [BYTE_W-1:0] wr_data;
  logic [BYTE_W-1:0] rx;
  logic [BYTE_W-1:0] mem [0:47];
  logic [BYTE_W-1:0] expm [0:47];
  int                n_errors = 0;
  int                compares = 0;

  assign scl = !(m_scl | (scl_oe & !scl_out));
  assign sda = !(m_sda | (sda_oe & !sda_out));

  irap_top u_irap_top (
    .i_clock(i_clock), .i_rst(i_rst), .i_on_battery(bat), .i_scl(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_wr_valid(wr_valid), .i_wr_ready(rdy),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr),
    .i_rd_data((rd_addr <= 6'h2f) ? mem[rd_addr] : 8'h5a)
  );

  irap_master u_irap_master (
    .i_clock(i_clock), .i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda), .o_hang(hang)
  );

  always #5 i_clock = ~i_clock;

  // register space drains the write queue, stalling at random
  always @(posedge i_clock) begin
    rdy <= !stall && ($urandom_range(3) != 0);
    if (wr_valid === 1'b1 && rdy) mem[wr_addr] <= wr_data;
  end

  always @(posedge hang) begin
    n_errors++;
    results;
  end

  function automatic logic [5:0] nxt(input logic [5:0] p);
    return (p == 6'h2f) ? 6'h00 : p + 6'h01;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_txn(input logic [7:0] ptr, input int n, input logic rs);
    logic [7:0] d;
    logic [5:0] p;
    p = ptr[5:0];
    u_irap_master.start;
    u_irap_master.xfer(8'ha2, 1'b1, rx, ack);
    check({7'h00, ack}, 8'h00);
    u_irap_master.xfer(ptr, 1'b1, rx, ack);
    check({7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_irap_master.xfer(d, 1'b1, rx, ack);
      check({7'h00, ack}, 8'h00);
      if (ptr <= 8'h2f) begin
        expm[p] = d;
        p = nxt(p);
      end
    end
    if (ptr <= 8'h2f) ep = p;
    if (!rs) u_irap_master.stop;
  endtask

  task automatic rd_txn(input int n);
    u_irap_master.start;
    u_irap_master.xfer(8'ha3, 1'b1, rx, ack);
    check({7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      u_irap_master.xfer(8'hff, i == n - 1, rx, ack);
      check(rx, expm[ep]);
      ep = nxt(ep);
    end
    u_irap_master.stop;
  endtask

  // neither the address nor the byte after it may be acknowledged
  task automatic nack_txn(input logic [7:0] a);
    u_irap_master.start;
    u_irap_master.xfer(a, 1'b1, rx, ack);
    check({7'h00, ack}, 8'h01);
    u_irap_master.xfer(8'h2a, 1'b1, rx, ack);
    check({7'h00, ack}, 8'h01);
    u_irap_master.stop;
  endtask

  task automatic done(input string s);
    $display("test %0s done", s);
  endtask

  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    logic [7:0] bad [3];
    int         p;
    int         n;
    bad = '{8'ha0, 8'ha6, 8'h22};
    void'($urandom(32'h50b9d625));
    for (int i = 0; i < 48; i++) begin
      mem[i] = 8'($urandom);
      expm[i] = mem[i];
    end
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    rd_txn(2);
    done("reset pointer");
    wr_txn(8'h2e, 4, 1'b0);
    wr_txn(8'h2e, 0, 1'b1);
    rd_txn(5);
    done("wrap");
    wr_txn(8'h05, 0, 1'b0);
    rd_txn(1);
    wr_txn(8'h30, 3, 1'b0);
    wr_txn(8'hff, 1, 1'b0);
    rd_txn(2);
    done("range");
    for (int i = 0; i < 3; i++) nack_txn(bad[i]);
    bat <= 1'b1;
    nack_txn(8'ha2);
    nack_txn(8'ha3);
    bat <= 1'b0;
    done("foreign and battery");
    stall <= 1'b1;
    fork
      begin
        repeat (3500) @(posedge i_clock);
        stall <= 1'b0;
      end
      wr_txn(8'h10, 20, 1'b0);
    join
    wr_txn(8'h10, 0, 1'b1);
    rd_txn(20);
    done("queue full");
    for (int j = 0; j < 4; j++) begin
      p = $urandom_range(47);
      n = $urandom_range(6, 1);
      wr_txn(8'(p), n, 1'b0);
      wr_txn(8'(p), 0, j[0]);
      rd_txn(n);
    end
    done("random");
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    ep = 6'h00;
    repeat (4) @(posedge i_clock);
    rd_txn(1);
    done("second reset");
    results;
  end
endmodule
